// [spi_master_slave_port_tb_top.sv]
// testbench top for the serial master/slave port
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_port_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_enable = 1'b0, cfg_master = 1'b0, cfg_clk_idle_high = 1'b0;
  logic cfg_sel_active_high = 1'b0, wakeup_source_enable_reg = 1'b0;
  logic [7:0] cfg_div = 8'h03; // half bit of four cycles
  logic [3:0] interrupt_enable_set_reg = 4'h0, evt_clear = 4'h0, tx_len_m1 = 4'hf;
  logic tx_valid = 1'b0, tx_eot = 1'b0, tx_rx_ignore = 1'b0, rx_ack = 1'b0;
  logic [15:0] tx_data = 16'h0000, rx_data_ff, mdl_rx;
  logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_sel = 1'b1; // bench as outside master
  logic [3:0] evt_flags_ff;
  logic tx_ready, rx_valid_ff, rx_overrun_ff, irq, wake_req, busy, mdl_miso;
  logic sck_out_ff, sck_oe_b, mosi_out_ff, mosi_oe_b, miso_out_ff, miso_oe_b;
  logic sel_out_ff, sel_oe_b, sck_in, mosi_in, miso_in, sel_in;
  logic [15:0] sel_rises = 16'h0000; // select releases seen on the wire
  int mismatches = 0, tests_run = 0;
  // wire levels from whoever drives each pin
  assign sck_in = sck_oe_b ? tb_sck : sck_out_ff;
  assign mosi_in = mosi_oe_b ? tb_mosi : mosi_out_ff;
  assign sel_in = sel_oe_b ? tb_sel : sel_out_ff;
  assign miso_in = miso_oe_b ? mdl_miso : miso_out_ff;
  sps_port dut (.*);
  sps_slave_model far (.sck(sck_in), .sel(sel_in), .mosi(mosi_in), .idle_hi(cfg_clk_idle_high),
    .sel_hi(cfg_sel_active_high), .tx_word(16'hc3a5), .miso(mdl_miso), .rx_word(mdl_rx));
  always #10 ref_clk = ~ref_clk;
  always @(posedge sel_in) sel_rises++;
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one word per call, then one idle edge so valid never double-drives
  task automatic push(input logic [15:0] d, input logic [3:0] l, input logic e);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_len_m1 <= l;
    tx_eot <= e;
    cyc(1);
    tx_valid <= 1'b0;
    cyc(1);
  endtask
  task automatic ack();
    rx_ack <= 1'b1;
    cyc(1);
    rx_ack <= 1'b0;
    cyc(2);
  endtask
  // ----------------------------------------
  // master: chained frames, unread receive
  // ----------------------------------------
  task automatic t_master_chain();
    cfg_master <= 1'b1;
    cyc(3);
    chk("sck drive", sck_oe_b, 1'b0);
    chk("mosi drive", mosi_oe_b, 1'b0);
    cfg_enable <= 1'b1;
    interrupt_enable_set_reg <= 4'h1;
    cyc(3);
    sel_rises = 16'h0000;
    push(16'h5a3c, 4'hf, 1'b0);
    push(16'h9617, 4'hf, 1'b1);
    repeat (3000) if (rx_overrun_ff !== 1'b1) @(posedge ref_clk);
    cyc(4);
    chk("overrun", rx_overrun_ff, 1'b1);
    chk("slave got", mdl_rx, 16'h9617);
    chk("master got", rx_data_ff, 16'hc3a5);
    chk("releases", sel_rises, 16'h0001);
    chk("sel idle", sel_out_ff, 1'b1);
    chk("irq", irq, 1'b1);
    evt_clear <= 4'hf;
    cyc(1);
    evt_clear <= 4'h0;
    cyc(2);
    chk("irq cleared", irq, 1'b0);
    ack();
    chk("rx taken", rx_valid_ff, 1'b0);
  endtask
  // ----------------------------------------
  // master: inverted polarities, short frame
  // ----------------------------------------
  task automatic t_polarity();
    cfg_clk_idle_high <= 1'b1;
    cfg_sel_active_high <= 1'b1;
    cyc(4);
    chk("sck idle high", sck_out_ff, 1'b1);
    chk("sel idle low", sel_out_ff, 1'b0);
    push(16'h00b4, 4'h7, 1'b1);
    repeat (3000) if (rx_valid_ff !== 1'b1) @(posedge ref_clk);
    cyc(4);
    chk("short out", mdl_rx, 16'h00b4);
    chk("short in", rx_data_ff, 16'h00c3);
    chk("sel released", sel_out_ff, 1'b0);
    ack();
  endtask
  // ----------------------------------------
  // slave: bench clocks a full word in and out
  // ----------------------------------------
  task automatic t_slave();
    int i;
    logic [15:0] got;
    cfg_master <= 1'b0;
    cfg_clk_idle_high <= 1'b0;
    cfg_sel_active_high <= 1'b0;
    wakeup_source_enable_reg <= 1'b1;
    interrupt_enable_set_reg <= 4'h4;
    push(16'h6d29, 4'hf, 1'b1);
    cyc(4);
    chk("miso off", miso_oe_b, 1'b1);
    chk("sck input", sck_oe_b, 1'b1);
    tb_sel <= 1'b0;
    cyc(6);
    chk("miso on", miso_oe_b, 1'b0);
    chk("sel event", evt_flags_ff[2], 1'b1);
    chk("wake", wake_req, 1'b1);
    for (i = 15; i >= 0; i--) begin
      tb_mosi <= i[0] ^ i[1]; // pattern 6666 from the index
      cyc(4);
      got[i] = miso_in;
      tb_sck <= 1'b1;
      cyc(4);
      tb_sck <= 1'b0;
    end
    cyc(4);
    tb_sel <= 1'b1;
    tb_mosi <= ~tb_mosi; // released line does not hold the last bit
    cyc(6);
    chk("slave in", rx_data_ff, 16'h6666);
    chk("slave out", got, 16'h6d29);
    chk("miso freed", miso_oe_b, 1'b1);
    chk("pin event", evt_flags_ff[3], 1'b1);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(3);
    chk("reset sel", sel_out_ff, 1'b1);
    chk("reset flags", evt_flags_ff, 4'h0);
    rst_b <= 1'b1;
    cyc(2);
    t_master_chain();
    t_polarity();
    t_slave();
    stop_test();
  end
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire

// [sps_fifo.v]
// parameterised fifo in flip-flops
`timescale 1ns/100ps
`default_nettype none
module sps_fifo #(
  parameter WIDTH = 22,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // word storage
  reg [AW-1:0] wr_ff; // write index
  reg [AW-1:0] rd_ff; // read index
  reg [AW:0] cnt_ff; // fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data = mem_ff[rd_ff];
  // pointer and level update
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
  // data write, no reset needed on storage
  always @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [sps_port.v]
// serial master/slave port core with transmit fifo
`timescale 1ns/100ps
`default_nettype none
`include "sps_regs.vh"
// ----------------------------------------
// overview
// ----------------------------------------
// the port is one engine pair sharing a transmit fifo and a receive holder.
// master mode: the engine pops a word, asserts select, waits half a bit,
// then toggles sck every cfg_div+1 cycles. miso is sampled on the leading
// half and mosi moves on the trailing half, msb first.
// a frame carries len+1 bits (1..16); the data sits right-aligned in the
// word, so the engine shifts it up before the first bit goes out.
// when a frame ends without its end-of-transfer mark, the engine parks in
// a hold state with select still active and waits for the next word, so
// software can chain frames into one long transfer.
// slave mode: all four pins pass a two-flop synchroniser before use.
// sck edges are found by comparing the second flop against a third copy.
// this limits the outside clock to well under a quarter of ref_clk; a
// faster master would see missed edges, which was judged acceptable for
// the area saved over a second clock domain.
// the slave never pops the fifo: it reloads its shift from the head word
// whenever it is deselected, so one word answers every slave frame until
// software replaces it.
// receive: a finished word not marked ignore overwrites the holder. transmit never
// waits for software to read, which is the point of the overrun flag:
// software learns a word was lost instead of the link stalling.
// events are sticky flags; a set in the same cycle as a clear wins, so
// no event can slip between a read and a clear.
// the clockless wake path compares the raw select pin against the second
// synchroniser flop. it is combinational on purpose: with the clock
// stopped the flops hold the last level, and any pin change shows up as a
// mismatch that the system wake logic can see.
// pin enables are active low. sck, mosi and select follow the master bit
// alone, not the enable bit, so the lines never float in master mode.
// miso is only driven by an enabled slave while it is selected, so several
// slaves may share the line.
// ----------------------------------------
// limitations
// ----------------------------------------
// clock phase is fixed: sample on the leading edge, change on trailing.
// the slave frame length comes from the fifo head, sixteen when empty.
// changing polarity or mode mid-frame gives one corrupt frame.
module sps_port (
  input wire ref_clk,
  input wire rst_b,
  // configuration
  input wire cfg_enable,
  input wire cfg_master,
  input wire cfg_clk_idle_high,
  input wire cfg_sel_active_high,
  input wire [`SPS_DIVW-1:0] cfg_div,
  input wire [`SPS_EVT_W-1:0] interrupt_enable_set_reg,
  input wire wakeup_source_enable_reg,
  // transmit stream: data, length-1, end of transfer, ignore receive
  input wire tx_valid,
  output wire tx_ready,
  input wire [`SPS_DW-1:0] tx_data,
  input wire [`SPS_LENW-1:0] tx_len_m1,
  input wire tx_eot,
  input wire tx_rx_ignore,
  // receive word
  output reg [`SPS_DW-1:0] rx_data_ff,
  output reg rx_valid_ff,
  input wire rx_ack,
  output reg rx_overrun_ff,
  // events
  input wire [`SPS_EVT_W-1:0] evt_clear,
  output reg [`SPS_EVT_W-1:0] evt_flags_ff,
  output wire irq,
  output wire wake_req,
  output wire busy,
  // pins: oe low while driving
  input wire sck_in,
  output reg sck_out_ff,
  output wire sck_oe_b,
  input wire mosi_in,
  output reg mosi_out_ff,
  output wire mosi_oe_b,
  input wire miso_in,
  output reg miso_out_ff,
  output wire miso_oe_b,
  input wire sel_in,
  output reg sel_out_ff,
  output wire sel_oe_b
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h1; // waiting for data
  localparam [3:0] ST_LEAD = 4'h2; // select asserted, half bit
  localparam [3:0] ST_SHIFT = 4'h4; // clocking bits
  localparam [3:0] ST_HOLD = 4'h8; // chained frame gap

  // fifo word width: data plus control
  localparam FW = `SPS_DW + `SPS_CTLW;

  // one bit level of select, given polarity
  function sel_level;
    input act;
    input hi;
    begin
      sel_level = hi ? act : ~act;
    end
  endfunction

  // ----------------------------------------
  // transmit fifo
  // ----------------------------------------
  wire [FW-1:0] f_in = {tx_rx_ignore, tx_eot, tx_len_m1, tx_data};
  wire [FW-1:0] f_out;
  wire f_valid;
  wire f_ready;
  sps_fifo #(
    .WIDTH(FW),
    .DEPTH(`SPS_FIFO_DEPTH),
    .AW(`SPS_FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(f_in),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_out)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [3:0] s1_ff; // first stage, read only by second
  reg [3:0] s2_ff; // second stage
  reg [3:0] s3_ff; // history for edges
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 4'h0;
    end else begin
      s1_ff <= {sel_in, miso_in, mosi_in, sck_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  wire sck_s = s2_ff[0];
  wire mosi_s = s2_ff[1];
  wire miso_s = s2_ff[2];
  wire sel_s = s2_ff[3];
  wire sel_act = (sel_s == sel_level(1'b1, cfg_sel_active_high));
  wire sel_chg = (s2_ff[3] != s3_ff[3]);
  wire sck_chg = (s2_ff[0] != s3_ff[0]);
  // leading edge leaves idle level, trailing edge returns
  wire sck_lead = sck_chg && (s3_ff[0] == cfg_clk_idle_high);
  wire sck_trail = sck_chg && (s2_ff[0] == cfg_clk_idle_high);

  // ----------------------------------------
  // master engine registers
  // ----------------------------------------
  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  reg [`SPS_DIVW-1:0] div_cnt_ff; // half bit timer
  reg [`SPS_LENW-1:0] bit_ff; // bits remaining minus one
  reg [`SPS_DW-1:0] sh_ff; // shift register
  reg [`SPS_DW-1:0] rsh_ff; // receive shift
  reg [`SPS_LENW-1:0] len_ff; // frame length minus one
  reg eot_ff; // release select after frame
  reg ign_ff; // drop received word
  reg phase_ff; // 0: leading half, 1: trailing half
  reg done_ff; // frame finished pulse
  wire tick = (div_cnt_ff == `SPS_CNT_ZERO);
  wire m_run = cfg_enable && cfg_master;
  assign f_ready = m_run && ((st_ff == ST_IDLE) || (st_ff == ST_HOLD));
  assign busy = (st_ff != ST_IDLE);

  // next state of master engine
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (m_run && f_valid) begin
          nxt_st = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          nxt_st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (tick && phase_ff && (bit_ff == `SPS_BIT_ZERO)) begin
          nxt_st = eot_ff ? ST_IDLE : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!m_run) begin
          nxt_st = ST_IDLE;
        end else if (f_valid) begin
          nxt_st = ST_LEAD;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // master datapath: shifting msb first, length from control
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      st_ff <= ST_IDLE;
      div_cnt_ff <= `SPS_DIV_RST;
      bit_ff <= `SPS_BIT_ZERO;
      sh_ff <= {`SPS_DW{1'b0}};
      rsh_ff <= {`SPS_DW{1'b0}};
      len_ff <= `SPS_BIT_ZERO;
      eot_ff <= 1'b1;
      ign_ff <= 1'b0;
      phase_ff <= 1'b0;
      done_ff <= 1'b0;
      sck_out_ff <= 1'b0;
      mosi_out_ff <= 1'b0;
      sel_out_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      done_ff <= 1'b0;
      div_cnt_ff <= tick ? cfg_div : div_cnt_ff - 1'b1;
      // select output: inactive when idle, held through chain
      sel_out_ff <= sel_level((nxt_st != ST_IDLE), cfg_sel_active_high);
      if (f_valid && f_ready) begin
        // load frame of 1..16 bits, aligned to top bit
        len_ff <= f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB];
        bit_ff <= f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB];
        eot_ff <= f_out[`SPS_CTL_EOT];
        // clear so a short frame lands right-aligned
        rsh_ff <= {`SPS_DW{1'b0}};
        ign_ff <= f_out[`SPS_CTL_RXIGN];
        sh_ff <= f_out[`SPS_DW-1:0] << (4'hf - f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB]);
        mosi_out_ff <= f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB] == 4'hf ?
          f_out[`SPS_DW-1] : f_out[f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB]];
        phase_ff <= 1'b0;
        div_cnt_ff <= cfg_div;
      end
      if (st_ff == ST_SHIFT && tick) begin
        phase_ff <= ~phase_ff;
        sck_out_ff <= ~sck_out_ff;
        if (!phase_ff) begin
          rsh_ff <= {rsh_ff[`SPS_DW-2:0], miso_s};
        end else begin
          sh_ff <= {sh_ff[`SPS_DW-2:0], 1'b0};
          mosi_out_ff <= sh_ff[`SPS_DW-2];
          if (bit_ff == `SPS_BIT_ZERO) begin
            done_ff <= 1'b1;
          end else begin
            bit_ff <= bit_ff - 1'b1;
          end
        end
      end else if (st_ff != ST_SHIFT) begin
        sck_out_ff <= cfg_clk_idle_high;
      end
    end
  end

  // ----------------------------------------
  // slave engine
  // ----------------------------------------
  reg [`SPS_DW-1:0] ssh_ff; // slave receive shift
  reg [`SPS_DW-1:0] stx_ff; // slave transmit shift
  reg [`SPS_LENW:0] scnt_ff; // bits received this frame
  reg s_done_ff; // slave word complete
  reg [`SPS_LENW-1:0] slen_ff; // slave frame length minus one
  wire s_run = cfg_enable && !cfg_master && sel_act;
  // slave takes length from last loaded control; a word per frame
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ssh_ff <= {`SPS_DW{1'b0}};
      stx_ff <= {`SPS_DW{1'b0}};
      scnt_ff <= 5'h00;
      s_done_ff <= 1'b0;
      slen_ff <= 4'hf;
      miso_out_ff <= 1'b0;
    end else begin
      s_done_ff <= 1'b0;
      if (!s_run) begin
        scnt_ff <= 5'h00;
        stx_ff <= f_valid ? f_out[`SPS_DW-1:0] : {`SPS_DW{1'b0}};
        slen_ff <= f_valid ? f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB] : 4'hf;
        miso_out_ff <= f_valid ? f_out[f_out[`SPS_CTL_LEN_MSB:`SPS_CTL_LEN_LSB]] : 1'b0;
      end else if (sck_lead) begin
        ssh_ff <= {ssh_ff[`SPS_DW-2:0], mosi_s};
        if (scnt_ff[`SPS_LENW-1:0] == slen_ff) begin
          scnt_ff <= 5'h00;
          s_done_ff <= 1'b1;
        end else begin
          scnt_ff <= scnt_ff + 1'b1;
        end
      end else if (sck_trail) begin
        // next bit out; counts down from top of frame
        miso_out_ff <= stx_ff[slen_ff - scnt_ff[`SPS_LENW-1:0]];
      end
    end
  end

  // ----------------------------------------
  // receive holding and events
  // ----------------------------------------
  wire m_word = done_ff && !ign_ff;
  wire rx_new = m_word || s_done_ff;
  // slave shift already holds the last bit when the done pulse stands
  wire [`SPS_DW-1:0] rx_word = s_done_ff ? ssh_ff : rsh_ff;
  reg [`SPS_EVT_W-1:0] evt_set;
  // overwrite on overrun so transmit never waits for reads
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_data_ff <= {`SPS_DW{1'b0}};
      rx_valid_ff <= 1'b0;
      rx_overrun_ff <= 1'b0;
    end else begin
      if (rx_new) begin
        rx_data_ff <= rx_word;
        rx_valid_ff <= 1'b1;
        rx_overrun_ff <= rx_overrun_ff | (rx_valid_ff && !rx_ack);
      end else if (rx_ack) begin
        rx_valid_ff <= 1'b0;
        rx_overrun_ff <= 1'b0;
      end
    end
  end

  // event sources
  always @* begin
    evt_set = {`SPS_EVT_W{1'b0}};
    evt_set[`SPS_EVT_TXDONE] = done_ff;
    evt_set[`SPS_EVT_RXRDY] = rx_new;
    evt_set[`SPS_EVT_SSCHG] = !cfg_master && sel_chg;
    evt_set[`SPS_EVT_PINACT] = !cfg_master && (sck_chg || sel_chg);
  end

  // sticky flags: set wins over clear
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      evt_flags_ff <= {`SPS_EVT_W{1'b0}};
    end else begin
      evt_flags_ff <= (evt_flags_ff & ~evt_clear) | evt_set;
    end
  end
  assign irq = |(evt_flags_ff & interrupt_enable_set_reg);
  // deep sleep wake: combinational from raw select pin, no clock needed
  assign wake_req = irq || (wakeup_source_enable_reg && !cfg_master &&
    interrupt_enable_set_reg[`SPS_EVT_SSCHG] &&
    (sel_in != s2_ff[3]));

  // ----------------------------------------
  // pin enables, low while driving
  // ----------------------------------------
  assign sck_oe_b = !cfg_master;
  assign mosi_oe_b = !cfg_master;
  assign sel_oe_b = !cfg_master;
  assign miso_oe_b = !(cfg_enable && !cfg_master && sel_act);
endmodule
`default_nettype wire

// [sps_port_sva.sv]
// assertions on the pins and flags of the serial port
`timescale 1ns/100ps
`default_nettype none
`include "sps_regs.vh"
module sps_port_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cfg_enable,
  input wire logic cfg_master,
  input wire logic cfg_clk_idle_high,
  input wire logic [`SPS_EVT_W-1:0] interrupt_enable_set_reg,
  input wire logic [`SPS_EVT_W-1:0] evt_flags_ff,
  input wire logic rx_ack,
  input wire logic rx_valid_ff,
  input wire logic irq,
  input wire logic wake_req,
  input wire logic busy,
  input wire logic sck_out_ff,
  input wire logic sck_oe_b,
  input wire logic mosi_oe_b,
  input wire logic miso_oe_b,
  input wire logic sel_oe_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // sck, mosi and select drive follow mode, not enable; miso needs an enabled slave
  // ----------------------------------------
  a_sck_drive_mode: assert property (sck_oe_b == !cfg_master)
    else $error("sck drive not tied to master mode");
  a_mosi_drive_mode: assert property (mosi_oe_b == !cfg_master)
    else $error("mosi drive not tied to master mode");
  a_sel_drive_mode: assert property (sel_oe_b == !cfg_master)
    else $error("select drive not tied to master mode");
  a_miso_drive_slave: assert property (!miso_oe_b |-> cfg_enable && !cfg_master)
    else $error("miso driven outside enabled slave");
  // ----------------------------------------
  // serial clock idles between transfers; received word, irq and wake checks
  // ----------------------------------------
  a_sck_idle_level: assert property (cfg_master && $past(cfg_master, 2) && $past(rst_b, 2)
    && cfg_clk_idle_high == $past(cfg_clk_idle_high, 2) && !busy && !$past(busy)
    |-> sck_out_ff == cfg_clk_idle_high) else $error("sck not at idle level");
  a_sck_only_busy: assert property (cfg_master && $past(cfg_master, 2) && $past(rst_b, 2)
    && cfg_clk_idle_high == $past(cfg_clk_idle_high, 2) && $changed(sck_out_ff)
    |-> busy || $past(busy)) else $error("sck toggled while idle");
  a_rx_word_stands: assert property (rx_valid_ff && !rx_ack |=> rx_valid_ff)
    else $error("received word dropped unread");
  a_irq_from_flags: assert property (irq == |(evt_flags_ff & interrupt_enable_set_reg))
    else $error("irq not enabled flags");
  a_wake_follows_irq: assert property (irq |-> wake_req)
    else $error("enabled event gives no wake");
endmodule
bind sps_port sps_port_chk chk (.*);
`default_nettype wire

// [sps_regs.vh]
// constants for the serial master/slave port
// Function
// - frames of one to sixteen bits
// - master or slave mode selectable
// - transmit never stalls on unread receive
// - control bits accompany transmit data
// - one select line, selectable polarity
// - slave pin activity raises clocked event
// - enabled events wake system from sleep
// - select change in slave wakes system
// - master drives clock, polarity programmable
// - clock toggles only during transfer
// - clock driven whenever master bit set
// - master drives mosi, slave samples it
// - mosi driven whenever master bit set
// - slave drives miso, master samples it
// - miso driven only enabled slave selected
// - select defaults to active low
`ifndef SPS_REGS_VH
`define SPS_REGS_VH
// ----------------------------------------
// widths and counts
// ----------------------------------------
`define SPS_DW 16
`define SPS_LENW 4
`define SPS_CTLW 6
`define SPS_FIFO_DEPTH 16
`define SPS_FIFO_AW 4
`define SPS_DIVW 8
`define SPS_DIV_RST 8'h04
`define SPS_CNT_ZERO 8'h00
`define SPS_BIT_ZERO 4'h0
// ----------------------------------------
// control field layout in fifo word, then event flag bits
// ----------------------------------------
`define SPS_CTL_LEN_LSB 16
`define SPS_CTL_LEN_MSB 19
`define SPS_CTL_EOT 20
`define SPS_CTL_RXIGN 21
`define SPS_EVT_W 4
`define SPS_EVT_TXDONE 0
`define SPS_EVT_RXRDY 1
`define SPS_EVT_SSCHG 2
`define SPS_EVT_PINACT 3
`endif

// [sps_slave_model.sv]
// behavioural far-side slave used while the port is master
`timescale 1ns/100ps
`default_nettype none
module sps_slave_model (
  input wire logic sck,
  input wire logic sel,
  input wire logic mosi,
  input wire logic idle_hi,
  input wire logic sel_hi,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [15:0] sh_ff; // reply word, rotates so chained frames repeat it
  initial begin
    miso = 1'b0;
    rx_word = 16'h0000;
  end
  // ----------------------------------------
  // select edges: load reply or let line wander
  // ----------------------------------------
  always @(sel) begin
    if (sel == sel_hi) begin
      sh_ff = tx_word;
      rx_word = 16'h0000;
      miso = tx_word[15];
    end else begin
      miso = ~miso; // released: never a stale bit
    end
  end
  // ----------------------------------------
  // sample on leading edge, change on trailing
  // ----------------------------------------
  always @(sck) begin
    if (sel == sel_hi && sck !== idle_hi) begin
      rx_word = {rx_word[14:0], mosi};
    end else if (sel == sel_hi) begin
      sh_ff = {sh_ff[14:0], sh_ff[15]};
      miso = sh_ff[15];
    end
  end
endmodule
`default_nettype wire
